/* File: verilog/pef_event_flags.sv */
// Contract
// R1: channel down-count compare match sets sticky flag
// R2: channel up-count compare match sets sticky flag
// R3: channel 0 down-count zero sets centre flag
// R4: period flag: zero edge-mode, zero-then-period centre-mode
// R5: falling edge on brake input sets its flag
// R6: write 1 clears brake flags; flags reset zero
// R7: 12-bit resume down-counter loaded from delay register
// R8: resume type selects counter zero or period edge
// R9: each flag raises interrupt only when enabled
// R10: up-compare enables only count in centre-aligned mode
// R11: write 0 keeps flag; set beats clear
//
// Decided for this implementation: the AHB-Lite register port.
module pef_event_flags
   import pef_pkg::*;
#(
   parameter int NUM_CH = 6
) (
   input wire logic CLK,
   input wire logic RST,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // counter match strobes, one cycle each; count direction and centre mode are levels
   input wire logic [NUM_CH-1:0] DOWN_MATCH,
   input wire logic [NUM_CH-1:0] UP_MATCH,
   input wire logic CH0_ZERO,
   input wire logic CH0_COUNT_DOWN,
   input wire logic CH0_PERIOD_MATCH,
   input wire logic CENTRE_ALIGNED,
   // brake inputs, levels
   input wire logic BRAKE_INPUT_ZERO,
   input wire logic BRAKE_INPUT_ONE,
   input wire logic LOW_VOLTAGE_DETECT,
   // outputs
   output logic IRQ,
   output logic LV_BRAKE_ACTIVE
);

   // ==========================================================
   // elaboration checks
   if (NUM_CH < 1 || NUM_CH > 6) begin : g_bad_num_ch
      $error("NUM_CH must lie in 1..6");
   end
   // the compare fields must not run into their neighbours
   if (UP_LSB + NUM_CH > BRK0_BIT) begin : g_bad_up_field
      $error("up-compare field overlaps the brake flags");
   end
   if (DOWN_LSB + NUM_CH > 32) begin : g_bad_down_field
      $error("down-compare field runs past the word");
   end
   if (DELAY_W < 1 || DELAY_W > 32) begin : g_bad_delay_w
      $error("DELAY_W must lie in 1..32");
   end
   if (LV_TYPE_BIT == LV_EN_BIT) begin : g_bad_lv_bits
      $error("resume type and brake enable share a bit");
   end

   // ==========================================================
   // flag bits present for this channel count
   function automatic logic [31:0] live_bits(input int n_ch);
      logic [31:0] m;
      m = WORD_ZERO;
      m[PERIOD_BIT] = 1'b1;
      m[BRK0_BIT] = 1'b1;
      m[BRK1_BIT] = 1'b1;
      m[CENTRE_BIT] = 1'b1;
      for (int i = 0; i < n_ch; i++) begin
         m[UP_LSB + i] = 1'b1;
         m[DOWN_LSB + i] = 1'b1;
      end
      return m & FLAG_MASK;
   endfunction : live_bits

   // absent channels keep zero flag and enable bits
   localparam logic [31:0] CH_MASK = live_bits(NUM_CH);

   // ==========================================================
   // state
   typedef struct packed {
      logic [31:0] flags;
      logic [31:0] enables;
      logic [DELAY_W-1:0] delay;
      logic lv_type;
      logic lv_en;
      pef_lv_state_t lv_state;
      logic [DELAY_W-1:0] resume_cnt;
      logic period_armed;
      logic wr_pend;
      logic [ADDR_W-1:0] wr_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic irq;
      logic brake_active;
   } pef_state_t;

   localparam pef_state_t STATE_RESET = '{
      flags: FLAGS_RESET,
      enables: WORD_ZERO,
      delay: DELAY_RESET,
      lv_type: 1'b0,
      lv_en: 1'b0,
      lv_state: LV_IDLE,
      resume_cnt: DELAY_RESET,
      period_armed: 1'b0,
      wr_pend: 1'b0,
      wr_addr: '0,
      hrdata: WORD_ZERO,
      hreadyout: 1'b1,
      hresp: 1'b0,
      irq: 1'b0,
      brake_active: 1'b0
   };

   pef_state_t s_reg;
   pef_state_t s_next;

   logic [31:0] set_vec;
   logic [31:0] clr_vec;
   logic [31:0] live_mask;
   logic period_event;
   logic addr_ok;
   logic [ADDR_W-1:0] rd_addr;
   logic brk0_fall;
   logic brk1_fall;

   // ==========================================================
   // brake pin edge detectors
   pef_fall_detect i_pef_fall_detect_zero (
      .clk(CLK),
      .rst(RST),
      .pin_level(BRAKE_INPUT_ZERO),
      .fell(brk0_fall)
   );

   pef_fall_detect i_pef_fall_detect_one (
      .clk(CLK),
      .rst(RST),
      .pin_level(BRAKE_INPUT_ONE),
      .fell(brk1_fall)
   );

   // ==========================================================
   // next state
   always_comb begin
      s_next = s_reg;
      set_vec = WORD_ZERO;
      clr_vec = WORD_ZERO;
      period_event = 1'b0;
      addr_ok = HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY;
      rd_addr = HADDR[ADDR_W-1:0];

      // ---------------------------------------------------------
      // hardware events
      for (int i = 0; i < NUM_CH; i++) begin
         if (DOWN_MATCH[i]) begin
            set_vec[DOWN_LSB + i] = 1'b1; // R1
         end
         if (UP_MATCH[i]) begin
            set_vec[UP_LSB + i] = 1'b1; // R2
         end
      end

      if (CH0_ZERO && CH0_COUNT_DOWN) begin
         set_vec[CENTRE_BIT] = 1'b1; // R3
      end

      // centre mode needs the zero point seen before the period point
      if (CENTRE_ALIGNED) begin
         if (CH0_ZERO) begin
            s_next.period_armed = 1'b1; // R4
         end else if (CH0_PERIOD_MATCH && s_reg.period_armed) begin
            period_event = 1'b1; // R4
            s_next.period_armed = 1'b0;
         end
      end else begin
         s_next.period_armed = 1'b0;
         period_event = CH0_ZERO; // R4
      end
      if (period_event) begin
         set_vec[PERIOD_BIT] = 1'b1; // R4
      end

      if (brk0_fall) begin
         set_vec[BRK0_BIT] = 1'b1; // R5
      end
      if (brk1_fall) begin
         set_vec[BRK1_BIT] = 1'b1; // R5
      end

      // ---------------------------------------------------------
      // bus write data phase
      if (s_reg.wr_pend) begin
         case (s_reg.wr_addr)
            OFS_IRQ_ENABLE: begin
               s_next.enables = HWDATA & CH_MASK;
            end
            OFS_EVENT_FLAGS: begin
               // only ones clear; zeros leave flags alone
               clr_vec = HWDATA & CH_MASK; // R6 R11
            end
            OFS_RESUME_DELAY: begin
               s_next.delay = HWDATA[DELAY_W-1:0]; // R7
            end
            OFS_BRAKE_CTRL: begin
               s_next.lv_type = HWDATA[LV_TYPE_BIT];
               s_next.lv_en = HWDATA[LV_EN_BIT];
            end
            default: begin
               // unmapped: ignored, still OKAY
            end
         endcase
      end

      // set after clear so a coincident event is kept
      s_next.flags = ((s_reg.flags & ~clr_vec) | set_vec) & CH_MASK; // R11 R6

      // ---------------------------------------------------------
      // low-voltage brake and resume
      case (s_reg.lv_state)
         LV_IDLE: begin
            if (s_reg.lv_en && LOW_VOLTAGE_DETECT) begin
               s_next.lv_state = LV_BRAKING;
            end
         end
         LV_BRAKING: begin
            if (!LOW_VOLTAGE_DETECT) begin
               if (s_reg.lv_type) begin
                  s_next.lv_state = LV_RESUME_PERIOD; // R8
               end else begin
                  s_next.lv_state = LV_RESUME_DELAY; // R8
                  s_next.resume_cnt = s_reg.delay; // R7
               end
            end
         end
         LV_RESUME_DELAY: begin
            if (LOW_VOLTAGE_DETECT) begin
               s_next.lv_state = LV_BRAKING;
            end else if (s_reg.resume_cnt == DELAY_RESET) begin
               s_next.lv_state = LV_IDLE; // R8
            end else begin
               s_next.resume_cnt = s_reg.resume_cnt - 1'b1; // R7
            end
         end
         LV_RESUME_PERIOD: begin
            if (LOW_VOLTAGE_DETECT) begin
               s_next.lv_state = LV_BRAKING;
            end else if (period_event) begin
               s_next.lv_state = LV_IDLE; // R8
            end
         end
         default: begin
            s_next.lv_state = LV_IDLE;
         end
      endcase
      s_next.brake_active = (s_next.lv_state != LV_IDLE);

      // ---------------------------------------------------------
      // bus address phase; zero wait states
      s_next.hreadyout = 1'b1;
      // never an error response
      s_next.hresp = 1'b0;
      s_next.wr_pend = addr_ok && HWRITE;
      if (addr_ok && HWRITE) begin
         s_next.wr_addr = rd_addr;
      end

      // read data taken from the next state so a write just ahead shows
      if (addr_ok && !HWRITE) begin
         case (rd_addr)
            OFS_IRQ_ENABLE: begin
               s_next.hrdata = s_next.enables;
            end
            OFS_EVENT_FLAGS: begin
               s_next.hrdata = s_next.flags;
            end
            OFS_RESUME_DELAY: begin
               s_next.hrdata = {{(32-DELAY_W){1'b0}}, s_next.delay};
            end
            OFS_BRAKE_CTRL: begin
               s_next.hrdata = WORD_ZERO;
               s_next.hrdata[LV_TYPE_BIT] = s_next.lv_type;
               s_next.hrdata[LV_EN_BIT] = s_next.lv_en;
            end
            default: begin
               s_next.hrdata = WORD_ZERO;
            end
         endcase
      end else begin
         s_next.hrdata = WORD_ZERO;
      end

      // ---------------------------------------------------------
      // interrupt: up-compare enables are dead in edge-aligned mode
      live_mask = CENTRE_ALIGNED ? CH_MASK : (CH_MASK & ~UP_MASK); // R10
      s_next.irq = |(s_next.flags & s_next.enables & live_mask); // R9
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_reg <= STATE_RESET; // R6
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign HRDATA = s_reg.hrdata;
   assign HREADYOUT = s_reg.hreadyout;
   assign HRESP = s_reg.hresp;
   assign IRQ = s_reg.irq;
   assign LV_BRAKE_ACTIVE = s_reg.brake_active;

endmodule : pef_event_flags

// ==========================================================
// falling-edge detector for one brake pin
module pef_fall_detect (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_level,
   output logic fell
);

   typedef struct packed {
      logic prev;
   } pef_fall_state_t;

   // reset low: a pin already low at release is no edge
   localparam pef_fall_state_t FALL_RESET = '{prev: 1'b0};

   pef_fall_state_t s_reg;
   pef_fall_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.prev = pin_level;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= FALL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // combinational so the flag sets on the edge itself
   assign fell = s_reg.prev && !pin_level; // R5

endmodule : pef_fall_detect

/* File: verilog/pef_pkg.sv */
package pef_pkg;

   // ==========================================================
   // register map (byte addresses, low address bits only)
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h54;
   localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h58;
   localparam logic [ADDR_W-1:0] OFS_RESUME_DELAY = 8'h5C;
   localparam logic [ADDR_W-1:0] OFS_BRAKE_CTRL = 8'h60;

   // ==========================================================
   // flag and enable layout (shared by both registers)
   localparam int DOWN_LSB = 24;
   localparam int UP_LSB = 8;
   localparam int CENTRE_BIT = 18;
   localparam int BRK1_BIT = 17;
   localparam int BRK0_BIT = 16;
   localparam int PERIOD_BIT = 0;
   localparam logic [31:0] FLAG_MASK = 32'h3F07_3F01;
   localparam logic [31:0] UP_MASK = 32'h0000_3F00;
   localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

   // ==========================================================
   // brake control bits kept here
   localparam int LV_TYPE_BIT = 15;
   localparam int LV_EN_BIT = 14;

   // ==========================================================
   // resume delay
   localparam int DELAY_W = 12;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 12'h000;

   // ==========================================================
   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      LV_IDLE,
      LV_BRAKING,
      LV_RESUME_DELAY,
      LV_RESUME_PERIOD
   } pef_lv_state_t;

endpackage : pef_pkg

/* File: tb/pef_event_flags_checker.sv */
module pef_event_flags_checker
   import pef_pkg::*;
#(
   parameter int NUM_CH = 6
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic [31:0] HRDATA,
   input wire logic HRESP,
   input wire logic IRQ,
   input wire logic LOW_VOLTAGE_DETECT,
   input wire logic LV_BRAKE_ACTIVE
);
   logic rd;
   logic wen_reg;
   logic off_reg;
   assign rd = HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE;
   // ==========================================================
   // shadow of an all-zero enable mask
   always_ff @(posedge CLK) begin
      wen_reg <= HSEL && HTRANS == HTRANS_NONSEQ && HWRITE
         && HADDR[7:0] == OFS_IRQ_ENABLE;
      off_reg <= RST || (wen_reg ? HWDATA == WORD_ZERO : off_reg);
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // ==========================================================
   // checks
   resp_okay_a: assert property (HRESP == 1'b0)
      else $error("bad resp");
   rdata_idle_a: assert property (!rd |=> HRDATA == WORD_ZERO)
      else $error("idle rdata");
   unmapped_zero_a: assert property (rd && HADDR[7:0] == 8'h40 |=> HRDATA == WORD_ZERO)
      else $error("unmapped rdata");
   flag_rsvd_a: assert property (
      rd && HADDR[7:0] == OFS_EVENT_FLAGS |=> (HRDATA & ~FLAG_MASK) == WORD_ZERO)
      else $error("flag reserved bits");
   delay_rsvd_a: assert property (
      rd && HADDR[7:0] == OFS_RESUME_DELAY |=> HRDATA[31:12] == 20'h00000)
      else $error("delay reserved bits");
   irq_masked_a: assert property (off_reg [*3] |-> !IRQ)
      else $error("irq while masked");
   lv_rise_a: assert property ($rose(LV_BRAKE_ACTIVE) |-> $past(LOW_VOLTAGE_DETECT))
      else $error("brake without detect");
   lv_fall_a: assert property ($fell(LV_BRAKE_ACTIVE) |-> !$past(LOW_VOLTAGE_DETECT))
      else $error("resume during detect");
endmodule : pef_event_flags_checker

/* File: tb/tb_top.sv */
module tb_top import pef_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [5:0] dn;
      logic [5:0] up;
      logic [4:0] ctl;
      logic [31:0] ex;
   } pef_row_t;
   logic clk, rst, hsel, hwrite, hresp, zero, cdn, pm, ca, bk, bk1, lvd, irq, lva;
   wire logic hready;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [5:0] dn, up;
   int n;
   int n_fail = 0;
   int checked = 0;
   // ==========================================================
   // ctl is {zero, count down, period match, centre, brakes}
   pef_row_t rows [8] = '{
      '{6'h3F, 6'h00, 5'h01, 32'h3F00_0000},
      '{6'h00, 6'h3F, 5'h03, 32'h0000_3F00},
      '{6'h00, 6'h00, 5'h19, 32'h0004_0001},
      '{6'h00, 6'h00, 5'h1B, 32'h0004_0000},
      '{6'h00, 6'h00, 5'h07, 32'h0000_0001},
      '{6'h00, 6'h00, 5'h07, 32'h0000_0000},
      '{6'h00, 6'h00, 5'h00, 32'h0003_0000},
      '{6'h00, 6'h00, 5'h00, 32'h0000_0000}
   };
   logic [7:0] ofs [5] = '{OFS_IRQ_ENABLE, OFS_EVENT_FLAGS, OFS_RESUME_DELAY,
      OFS_BRAKE_CTRL, 8'h40};
   pef_event_flags i_pef_event_flags (
      .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP(hresp), .DOWN_MATCH(dn), .UP_MATCH(up), .CH0_ZERO(zero), .CH0_COUNT_DOWN(cdn),
      .CH0_PERIOD_MATCH(pm), .CENTRE_ALIGNED(ca), .BRAKE_INPUT_ZERO(bk),
      .BRAKE_INPUT_ONE(bk1), .LOW_VOLTAGE_DETECT(lvd), .IRQ(irq), .LV_BRAKE_ACTIVE(lva)
   );
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic close_out();
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   // ==========================================================
   // bus: hold each phase until hready is sampled high
   task automatic rdy();
      int w;
      w = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         w++;
         if (w > 50) begin
            n_fail++;
            close_out();
         end
         @(posedge clk);
      end
   endtask : rdy
   // p pulses the down matches in the data phase edge
   task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [5:0] p);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      dn <= p;
      rdy();
      q = hrdata;
   endtask : xf
   initial begin
      {rst, hsel, hwrite, zero, cdn, pm, ca, lvd, bk, bk1} <= 10'h203;
      {haddr, hwdata, htrans, dn, up} <= '0;
      hsize <= 3'h2;
      cyc(16);
      rst <= 1'b0;
      cyc(1);
      foreach (ofs[i]) begin
         xf(ofs[i], 1'b0, '0, 6'h00);
         chk("reset", q, '0);
      end
      foreach (rows[i]) begin
         {zero, cdn, pm, ca, bk} <= rows[i].ctl;
         bk1 <= rows[i].ctl[0];
         {dn, up} <= {rows[i].dn, rows[i].up};
         cyc(1);
         {up, zero, pm} <= '0;
         xf(OFS_EVENT_FLAGS, 1'b0, '0, 6'h00);
         chk("flags", q, rows[i].ex);
         xf(OFS_EVENT_FLAGS, 1'b1, rows[i].ex, 6'h00);
         xf(OFS_EVENT_FLAGS, 1'b0, '0, 6'h00);
         chk("clear", q, '0);
      end
      xf(OFS_EVENT_FLAGS, 1'b1, '0, 6'h01);
      dn <= '0;
      xf(OFS_EVENT_FLAGS, 1'b1, 32'h0100_0000, 6'h01);
      dn <= '0;
      xf(OFS_EVENT_FLAGS, 1'b0, '0, 6'h00);
      chk("set wins", q, 32'h0100_0000);
      // one pin alone: only its own flag may set
      bk <= 1'b1;
      bk1 <= 1'b1;
      cyc(2);
      bk1 <= 1'b0;
      cyc(1);
      xf(OFS_EVENT_FLAGS, 1'b0, '0, 6'h00);
      chk("brake one", q, 32'h0102_0000);
      xf(OFS_RESUME_DELAY, 1'b1, 32'hFFFF_FFFF, 6'h00);
      xf(8'h40, 1'b1, 32'hFFFF_FFFF, 6'h00);
      xf(OFS_RESUME_DELAY, 1'b0, '0, 6'h00);
      chk("delay", q, 32'h0000_0FFF);
      // the pending ch0 flag must stay masked
      xf(OFS_IRQ_ENABLE, 1'b1, 32'h0400_0100, 6'h04);
      dn <= '0;
      cyc(3);
      chk("irq on", 32'(irq), 32'h1);
      xf(OFS_IRQ_ENABLE, 1'b1, '0, 6'h00);
      cyc(3);
      chk("irq masked", 32'(irq), 32'h0);
      xf(OFS_EVENT_FLAGS, 1'b1, 32'h0500_0000, 6'h00);
      xf(OFS_IRQ_ENABLE, 1'b1, 32'h0000_0100, 6'h00);
      up <= 6'h01;
      cyc(1);
      up <= '0;
      cyc(3);
      chk("irq edge", 32'(irq), 32'h0);
      ca <= 1'b1;
      cyc(3);
      chk("irq centre", 32'(irq), 32'h1);
      xf(OFS_EVENT_FLAGS, 1'b1, 32'h0000_0100, 6'h00);
      cyc(3);
      chk("irq clear", 32'(irq), 32'h0);
      ca <= 1'b0;
      xf(OFS_RESUME_DELAY, 1'b1, 32'h0000_0006, 6'h00);
      xf(OFS_BRAKE_CTRL, 1'b1, 32'h0000_4000, 6'h00);
      lvd <= 1'b1;
      cyc(4);
      chk("lv on", 32'(lva), 32'h1);
      lvd <= 1'b0;
      n = 0;
      while (lva === 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      // delay 6 plus two cycles, seen one edge late by the loop
      chk("lv delay", 32'(n), 32'h0000_0009);
      xf(OFS_BRAKE_CTRL, 1'b1, 32'h0000_C000, 6'h00);
      lvd <= 1'b1;
      cyc(4);
      lvd <= 1'b0;
      cyc(20);
      chk("lv hold", 32'(lva), 32'h1);
      zero <= 1'b1;
      cyc(1);
      zero <= 1'b0;
      cyc(3);
      chk("lv period", 32'(lva), 32'h0);
      dn <= 6'h3F;
      cyc(1);
      {dn, rst} <= 7'h01;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      xf(OFS_EVENT_FLAGS, 1'b0, '0, 6'h00);
      chk("rerun", q, '0);
      close_out();
   end
endmodule : tb_top
bind pef_event_flags pef_event_flags_checker #(.NUM_CH(NUM_CH)) i_pef_event_flags_checker (
   .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HWDATA(HWDATA), .HRDATA(HRDATA), .HRESP(HRESP), .IRQ(IRQ),
   .LOW_VOLTAGE_DETECT(LOW_VOLTAGE_DETECT), .LV_BRAKE_ACTIVE(LV_BRAKE_ACTIVE)
);
